// ### biu_model.sv
// Model of the bus interface unit and of an external bus-hold master.
// Assumes a level refresh request answered by ack and done pulses.
`timescale 1ns/1ps
`default_nettype none
module biu_model (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset,
  // Answer speed and hold wish.
  input  wire logic slow,
  input  wire logic hold_want,
  // Refresh handshake and bus hold.
  input  wire logic refresh_req,
  output var  logic refresh_ack,
  output var  logic refresh_done,
  input  wire logic bus_hold_grant,
  output var  logic hold_req
);
  logic [3:0] wait_q;
  logic       busy_q;
  logic       grant_q;
  always_ff @(posedge clk_sys) begin
    refresh_ack  <= 1'b0;
    refresh_done <= 1'b0;
    if (reset) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (busy_q) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == 4'h3) begin
        refresh_done <= 1'b1;
        busy_q       <= 1'b0;
      end
    end else if (refresh_req && !bus_hold_grant) begin
      wait_q <= wait_q + 4'h1;
      if (!slow || wait_q == 4'h6) begin
        refresh_ack <= 1'b1;
        busy_q      <= 1'b1;
        wait_q      <= 4'h0;
      end
    end
  end
  // The hold master backs off for one clock when the grant is taken away.
  always_ff @(posedge clk_sys) begin
    grant_q  <= bus_hold_grant;
    hold_req <= !reset && hold_want && !(grant_q && !bus_hold_grant && hold_req);
  end
endmodule : biu_model
`default_nettype wire

// ### clk_div_if.sv
// Interface carrying the power-save settings to the clock divider.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface clk_div_if;
  logic       psave_en;
  logic [2:0] div_sel;
  logic       tick;
  modport ctrl (output psave_en, output div_sel, input tick);
  modport div  (input psave_en, input div_sel, output tick);
endinterface : clk_div_if
`default_nettype wire

// ### clk_divider.sv
// Clock divider producing the internal clock enable tick and its output clock image.
// Assumes the division factor is 2 to the power of the selected field.
`timescale 1ns/1ps
`default_nettype none
module clk_divider (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset,
  // Settings and tick.
  clk_div_if.div    cfg,
  // Divided clock image.
  output var  logic clk_image_q
);
  import refresh_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] limit;

  // Division factor 2**div_sel; 0 selects divide by one.
  assign limit = (8'h01 << cfg.div_sel) - 8'h01;
  assign cfg.tick = !cfg.psave_en || (cnt_q == limit);

  always_ff @(posedge clk_sys) begin
    if (reset || !cfg.psave_en || cnt_q == limit) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_image_q <= 1'b0;
    end else if (!cfg.psave_en || limit == 8'h00) begin
      clk_image_q <= ~clk_image_q;
    end else begin
      // High for the first half of each divided period, so divide by two still toggles.
      clk_image_q <= (cnt_q <= (limit >> 1)) ? 1'b1 : 1'b0;
    end
  end
endmodule : clk_divider
`default_nettype wire

// ### refresh_pkg.sv
// Package with register map, field layouts and constants of the refresh and power-save block.
// Assumes a 32-bit APB register bus with byte addresses.
package refresh_pkg;
  localparam logic [7:0]  ADDR_PARTITION   = 8'hf0;
  localparam logic [7:0]  ADDR_INTERVAL    = 8'he2;
  localparam logic [7:0]  ADDR_ENABLE      = 8'he4;
  localparam logic [7:0]  ADDR_POWER_DIV   = 8'hf4;
  localparam logic [7:0]  ADDR_STATUS      = 8'hf8;
  localparam int          PART_LSB         = 9;
  localparam int          PART_W           = 7;
  localparam int          CNT_W            = 9;
  localparam int          DIV_W            = 3;
  localparam int          ENABLE_BIT       = 15;
  localparam int          PSAVE_BIT        = 15;
  localparam logic [8:0]  RAC_SEED         = 9'h1ff;
  localparam logic [8:0]  CNT_ZERO         = 9'h000;
  localparam logic [8:0]  CNT_ONE          = 9'h001;
  localparam logic [2:0]  DIV_RESET        = 3'h0;
  localparam logic [31:0] READ_INVALID     = 32'h00000000;
  typedef enum logic [2:0] {
    REQ_IDLE = 3'b001,
    REQ_WAIT = 3'b010,
    REQ_BUSY = 3'b100
  } req_state_t;
endpackage : refresh_pkg

// ### refresh_properties.sv
// Checker of the refresh block's port behaviour.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module refresh_properties (
  // Watched ports.
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        enhanced_mode,
  input wire logic        refresh_req,
  input wire logic [19:0] refresh_addr,
  input wire logic        refresh_ack,
  input wire logic        refresh_done,
  input wire logic        hold_req,
  input wire logic        bus_hold_grant_in,
  input wire logic        bus_hold_grant
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_ack_ends_req: assert property (refresh_ack |=> !refresh_req) else $error("request outlived ack");
  a_req_held: assert property (refresh_req && !refresh_ack |=> refresh_req) else $error("request dropped");
  a_grant_yields: assert property (refresh_req |=> !bus_hold_grant) else $error("grant kept");
  a_grant_cause: assert property (bus_hold_grant |-> $past(hold_req) && $past(bus_hold_grant_in))
    else $error("grant without hold");
  a_compat_quiet: assert property (!enhanced_mode [*8] |-> !$rose(refresh_req)) else $error("compat refresh");
  a_addr_gap: assert property (refresh_addr[12:9] == 4'h0) else $error("address gap bits set");
  a_compat_read: assert property (!enhanced_mode [*6] ##0 (psel && !penable && !pwrite) |=> prdata == 32'h0)
    else $error("compat read data");
  a_done_steps: assert property (refresh_done |-> ##[1:3] $changed(refresh_addr[8:0]))
    else $error("counter stuck");
  cover property ($rose(refresh_req));
  cover property (refresh_done);
  cover property ($fell(bus_hold_grant) && hold_req);
endmodule : refresh_properties
bind refresh_unit refresh_properties i_props (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .enhanced_mode(enhanced_mode), .refresh_req(refresh_req),
  .refresh_addr(refresh_addr), .refresh_ack(refresh_ack), .refresh_done(refresh_done), .hold_req(hold_req),
  .bus_hold_grant_in(bus_hold_grant_in), .bus_hold_grant(bus_hold_grant));
`default_nettype wire

// ### refresh_unit.sv
// Refresh request generator and power-save control with an APB register slave.
// Assumes the bus interface unit answers refresh requests with a completion pulse.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Expired interval requests memory read refresh
// - Refresh works only in enhanced mode
// - Matching chip select applies during refresh; here no chip select is decoded or driven
// - Unmatched refresh ends on external ready; here every refresh ends on the refresh_done pulse
// - Drop hold grant when refresh pending
// - Registers accessible only in enhanced mode
// - Compatible mode ignores writes, reads invalid
// - Unwritable fields ignore writes, read zero
// - Address from partition plus 9-bit counter
// - Setting run bit loads countdown
// - Countdown decrements each system clock out
// - At one, request and reload
// - Clearing run bit clears countdown only
// - Power-save divides clock, shown on output
// - Divider register: 3-bit factor, enable bit
// - Internal logic runs on divided clock; here only the countdown steps on the divided tick
// - Interrupt clears power-save enable bit
// - Division starts and stops on write
module refresh_unit (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Mode and interrupt.
  input  wire logic        enhanced_mode,
  input  wire logic        irq_taken,
  // Bus interface unit.
  output var  logic        refresh_req,
  output var  logic [19:0] refresh_addr,
  input  wire logic        refresh_ack,
  input  wire logic        refresh_done,
  // Bus hold.
  input  wire logic        hold_req,
  input  wire logic        bus_hold_grant_in,
  output var  logic        bus_hold_grant,
  // Clock output.
  output var  logic        system_clock_out
);
  import refresh_pkg::*;

  // Mode synchroniser.
  logic             mode_s1_q;
  logic             mode_s2_q;
  logic             mode_s3_q;
  logic             enh_q;

  // Register fields.
  logic [PART_W-1:0] partition_bits_q;
  logic [CNT_W-1:0] interval_reload_value_q;
  logic [CNT_W-1:0] interval_countdown_q;
  logic             run_q;
  logic [CNT_W-1:0] rac_q;
  logic             psave_q;
  logic [2:0]       div_q;
  logic             overrun_q;

  // Bus decode and strobes.
  logic             wr_en;
  logic             rd_en;
  logic             setup_rd;
  logic             sel_partition;
  logic             sel_interval;
  logic             sel_enable;
  logic             sel_power;
  logic             sel_status;
  logic             wr_partition;
  logic             wr_interval;
  logic             wr_enable;
  logic             wr_power;
  logic [31:0]      rd_word;

  // Refresh sequencing.
  logic             expire;
  logic             count_step;
  logic             run_set;
  logic             run_clear;
  logic             cycle_end;
  logic             pending_q;
  logic [19:0]      addr_next;
  logic             grant_allow;
  req_state_t       state_q;
  clk_div_if        div_bus ();

  // Mode strap passes three flops; it counts once stages two and three agree.
  // A mode change therefore takes effect about four cycles after the pin moves.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      mode_s3_q <= 1'b0;
      enh_q     <= 1'b0;
    end else begin
      mode_s1_q <= enhanced_mode;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
      if (mode_s2_q == mode_s3_q) begin
        enh_q <= mode_s3_q;
      end
    end
  end

  // The slave never stalls and never flags an error; refused accesses are quietly dropped.
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite && enh_q;
  assign rd_en   = psel && !pwrite && enh_q;

  // Register selects, decoded from the byte address.
  assign sel_partition = (paddr == ADDR_PARTITION);
  assign sel_interval  = (paddr == ADDR_INTERVAL);
  assign sel_enable    = (paddr == ADDR_ENABLE);
  assign sel_power     = (paddr == ADDR_POWER_DIV);
  assign sel_status    = (paddr == ADDR_STATUS);

  // Write strobes fire once, on the access edge, and only in enhanced mode.
  assign wr_partition = wr_en && sel_partition;
  assign wr_interval  = wr_en && sel_interval;
  assign wr_enable    = wr_en && sel_enable;
  assign wr_power     = wr_en && sel_power;

  // Read data is captured on the setup edge so that it stands through the access phase.
  assign setup_rd = rd_en && !penable;

  // Read word assembly; fields that cannot be written read back as zeros.
  always_comb begin
    rd_word = READ_INVALID;
    if (sel_partition) begin
      rd_word = {16'h0000, partition_bits_q, 9'h000};
    end else if (sel_interval) begin
      rd_word = {23'h000000, interval_reload_value_q};
    end else if (sel_enable) begin
      rd_word = {16'h0000, run_q, 6'h00, interval_countdown_q};
    end else if (sel_power) begin
      rd_word = {16'h0000, psave_q, 12'h000, div_q};
    end else if (sel_status) begin
      rd_word = {21'h000000, overrun_q, pending_q, rac_q};
    end
  end

  // In compatible mode a setup cycle loads the invalid word, so stale data never leaks out.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= READ_INVALID;
    end else if (setup_rd) begin
      prdata <= rd_word;
    end else if (psel && !penable) begin
      prdata <= READ_INVALID;
    end
  end

  // Partition bits; cleared by reset so refresh addresses start in region zero.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      partition_bits_q <= '0;
    end else if (wr_partition) begin
      partition_bits_q <= pwdata[PART_LSB +: PART_W];
    end
  end

  // Interval reload value, counted in divided clock cycles.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interval_reload_value_q <= '0;
    end else if (wr_interval) begin
      interval_reload_value_q <= pwdata[CNT_W-1:0];
    end
  end

  // Power-save enable; an interrupt clear wins over a software write in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      psave_q <= 1'b0;
    end else if (irq_taken) begin
      psave_q <= 1'b0;
    end else if (wr_power) begin
      psave_q <= pwdata[PSAVE_BIT] && enh_q;
    end else if (!enh_q) begin
      psave_q <= 1'b0;
    end
  end

  // Division factor field.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_q <= DIV_RESET;
    end else if (wr_power && !irq_taken) begin
      div_q <= pwdata[DIV_W-1:0];
    end
  end

  // Settings handed to the divider, which turns them into a tick and the clock image.
  assign div_bus.psave_en = psave_q;
  assign div_bus.div_sel  = div_q;

  clk_divider u_div (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .cfg         (div_bus.div),
    .clk_image_q (system_clock_out)
  );

  // The countdown only moves on divided ticks, so power-save slows refresh too.
  assign count_step = run_q && div_bus.tick;
  assign run_set    = wr_enable && pwdata[ENABLE_BIT] && !run_q;
  assign run_clear  = wr_enable && !pwdata[ENABLE_BIT];
  assign expire     = count_step && interval_countdown_q == CNT_ONE && !run_clear;

  // Run bit; leaving enhanced mode stops the unit.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run_q <= 1'b0;
    end else if (!enh_q) begin
      run_q <= 1'b0;
    end else if (wr_enable) begin
      run_q <= pwdata[ENABLE_BIT];
    end
  end

  // Interval countdown. A write that keeps the run bit set holds the count for that cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interval_countdown_q <= CNT_ZERO;
    end else if (!enh_q) begin
      interval_countdown_q <= CNT_ZERO;
    end else if (run_set) begin
      interval_countdown_q <= interval_reload_value_q;
    end else if (run_clear) begin
      interval_countdown_q <= CNT_ZERO;
    end else if (wr_enable) begin
      interval_countdown_q <= interval_countdown_q;
    end else if (expire) begin
      interval_countdown_q <= interval_reload_value_q;
    end else if (count_step && interval_countdown_q != CNT_ZERO) begin
      interval_countdown_q <= interval_countdown_q - CNT_ONE;
    end
  end

  // A refresh cycle ends on the completion pulse while the unit owns the bus.
  assign cycle_end = (state_q == REQ_BUSY) && refresh_done;

  // Request handshake with the bus interface unit; one request is in flight at a time.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= REQ_IDLE;
    end else begin
      unique case (state_q)
        REQ_IDLE: begin
          if (expire) begin
            state_q <= REQ_WAIT;
          end
        end
        REQ_WAIT: begin
          if (refresh_ack) begin
            state_q <= REQ_BUSY;
          end
        end
        REQ_BUSY: begin
          // Completion comes from the refresh_done pulse of the bus interface unit.
          if (cycle_end) begin
            state_q <= REQ_IDLE;
          end
        end
        default: state_q <= REQ_IDLE;
      endcase
    end
  end

  // Pending flag, seen by software and by the hold arbiter.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else if (state_q == REQ_IDLE && expire) begin
      pending_q <= 1'b1;
    end else if (cycle_end) begin
      pending_q <= 1'b0;
    end
  end

  // Sticky flag: an expiry while a request is still outstanding is lost.
  // Reading the status register clears it; a new loss in the same cycle wins.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overrun_q <= 1'b0;
    end else if (expire && state_q != REQ_IDLE) begin
      overrun_q <= 1'b1;
    end else if (setup_rd && sel_status) begin
      overrun_q <= 1'b0;
    end
  end

  // The request stays up until the bus interface unit accepts it.
  assign refresh_req = (state_q == REQ_WAIT);

  // Address counter is a 9-bit maximal-length shift register.
  // It never reaches zero, so the seed must be non-zero.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rac_q <= RAC_SEED;
    end else if (cycle_end) begin
      rac_q <= {rac_q[7:0], rac_q[8] ^ rac_q[4]};
    end
  end

  // Partition bits on the top address lines, counter on the bottom ones.
  assign addr_next = {partition_bits_q, 4'h0, rac_q};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      refresh_addr <= 20'h00000;
    end else begin
      refresh_addr <= addr_next;
    end
  end

  // Grant withdrawn while a refresh is pending; the hold master must release.
  // A master that kept hold asserted would otherwise starve refresh for good.
  assign grant_allow = bus_hold_grant_in && hold_req && !pending_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_hold_grant <= 1'b0;
    end else begin
      bus_hold_grant <= grant_allow;
    end
  end
endmodule : refresh_unit
`default_nettype wire

// ### testbench.sv
// Self-checking testbench of the refresh and power-save block.
// Assumes the partner model answers refresh cycles and drives the hold request.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import refresh_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic enhanced_mode = 1'b1, irq_taken = 1'b0, slow = 1'b0, hold_want = 1'b0, grant_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, refresh_req, refresh_ack, refresh_done, hold_req, bus_hold_grant, system_clock_out;
  logic [19:0] refresh_addr;
  int miscompares = 0, total_checks = 0;
  refresh_unit i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enhanced_mode(enhanced_mode), .irq_taken(irq_taken), .refresh_req(refresh_req),
    .refresh_addr(refresh_addr), .refresh_ack(refresh_ack), .refresh_done(refresh_done), .hold_req(hold_req),
    .bus_hold_grant_in(grant_in), .bus_hold_grant(bus_hold_grant), .system_clock_out(system_clock_out));
  biu_model i_biu (.clk_sys(clk_sys), .reset(reset), .slow(slow), .hold_want(hold_want),
    .refresh_req(refresh_req), .refresh_ack(refresh_ack), .refresh_done(refresh_done),
    .bus_hold_grant(bus_hold_grant), .hold_req(hold_req));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdata   = prdata;
    chk("slave error", 32'h0, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic count_rises(input string n, input int e);
    int rises;
    logic last;
    rises = 0;
    last  = system_clock_out;
    repeat (64) begin
      @(posedge clk_sys);
      if (system_clock_out === 1'b1 && last === 1'b0) rises++;
      last = system_clock_out;
    end
    chk(n, e, rises);
  endtask : count_rises
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask : rd
  task automatic t_regs;
    rd(ADDR_PARTITION, 32'h0, "partition reset");
    rd(ADDR_ENABLE, 32'h0, "enable reset");
    apb(1'b1, ADDR_PARTITION, 32'hffffffff);
    rd(ADDR_PARTITION, 32'h0000fe00, "partition fields");
    apb(1'b1, ADDR_INTERVAL, 32'hffffffff);
    rd(ADDR_INTERVAL, 32'h000001ff, "interval fields");
    rd(8'hfc, 32'h0, "unmapped");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_refresh;
    apb(1'b1, ADDR_PARTITION, 32'h0000a400);
    apb(1'b1, ADDR_INTERVAL, 32'h00000012);
    hold_want <= 1'b1;
    grant_in  <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("hold grant", 32'h1, {31'h0, bus_hold_grant});
    apb(1'b1, ADDR_ENABLE, 32'h00008000);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 300 && refresh_req !== 1'b1; i++) @(posedge clk_sys);
      chk("refresh request", 32'h1, {31'h0, refresh_req});
      chk("refresh partition", 32'h52, {25'h0, refresh_addr[19:13]});
      chk("refresh counter", (k == 0) ? 32'h1ff : 32'h1fe, {23'h0, refresh_addr[8:0]});
      for (int i = 0; i < 300 && refresh_done !== 1'b1; i++) @(posedge clk_sys);
      slow <= 1'b1;
    end
    apb(1'b1, ADDR_ENABLE, 32'h0);
    rd(ADDR_ENABLE, 32'h0, "countdown cleared");
    rd(ADDR_STATUS, 32'h000001fc, "address counter");
    hold_want <= 1'b0;
    $display("t_refresh done");
  endtask : t_refresh
  task automatic t_compat;
    enhanced_mode <= 1'b0;
    repeat (8) @(posedge clk_sys);
    apb(1'b1, ADDR_PARTITION, 32'h0);
    rd(ADDR_PARTITION, 32'h0, "compat read");
    enhanced_mode <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(ADDR_PARTITION, 32'h0000a400, "compat write ignored");
    $display("t_compat done");
  endtask : t_compat
  task automatic t_psave;
    apb(1'b1, ADDR_POWER_DIV, 32'h00008003);
    rd(ADDR_POWER_DIV, 32'h00008003, "power divider");
    count_rises("divided clock out", 8);
    irq_taken <= 1'b1;
    @(posedge clk_sys);
    irq_taken <= 1'b0;
    rd(ADDR_POWER_DIV, 32'h00000003, "irq clears save");
    count_rises("full speed clock out", 32);
    $display("t_psave done");
  endtask : t_psave
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (5) @(posedge clk_sys);
    t_regs();
    t_refresh();
    t_compat();
    t_psave();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
